// >>> rtl/wdcs_defines.svh
// Offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDCS_DEFINES_SVH
`define WDCS_DEFINES_SVH
`define WDCS_OFF_WDCTL 8'hd8
`define WDCS_OFF_IRQEN 8'he8
`define WDCS_OFF_IRQPRI 8'hf8
`define WDCS_OFF_TAKEY 8'hc7
`define WDCS_OFF_RSTCTL 8'hfc
`define WDCS_BIT_BAUD2 7
`define WDCS_BIT_POR 6
`define WDCS_BIT_IRQF 3
`define WDCS_BIT_RCAUSE 2
`define WDCS_BIT_RSTEN 1
`define WDCS_BIT_RESTART 0
`define WDCS_BIT_IRQEN 4
`define WDCS_BIT_IRQPRI 4
`define WDCS_IRQEN_RSVD 8'he0
`define WDCS_WDCTL_POR 8'h40
`define WDCS_KEY1 8'haa
`define WDCS_KEY2 8'h55
`define WDCS_KEY_MCS 3
`define WDCS_CLKS_PER_MC 4
`define WDCS_RST_DELAY 512
`define WDCS_TIMEOUT 20'h40000
`endif

// >>> rtl/wdcs_pkg.sv
// Types shared by the watchdog control and status block
package wdcs_pkg;
	typedef enum logic [1:0] {
		WDCS_KEY_IDLE,
		WDCS_KEY_HALF,
		WDCS_KEY_OPEN
	} wdcs_key_t;
	typedef enum logic [1:0] {
		WDCS_WD_RUN,
		WDCS_WD_DELAY
	} wdcs_wd_t;
endpackage : wdcs_pkg

// >>> rtl/wdcs_top.sv
// Watchdog control, status and timed-access logic behind an AXI4-Lite slave
`include "wdcs_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module wdcs_top
	import wdcs_pkg::*;
#(
	parameter int TIMEOUT_CLKS = `WDCS_TIMEOUT,
	parameter int RST_DELAY = `WDCS_RST_DELAY,
	parameter int KEY_CLKS = `WDCS_KEY_MCS * `WDCS_CLKS_PER_MC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_event,
	input wire logic ext_reset,
	input wire logic power_fail,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic watchdog_reset_out,
	output logic watchdog_irq_req,
	output logic watchdog_irq_high,
	output logic port1_baud_double
);
	logic [7:0] wdctl_reg;
	logic [7:0] irq_enable_reg;
	logic [7:0] irq_priority_reg;
	logic [31:0] aw_addr_reg;
	logic aw_have_reg;
	logic [31:0] w_data_reg;
	logic w_have_reg;
	logic [3:0] w_strb_reg;
	wdcs_key_t key_reg;
	logic [15:0] key_cnt_reg;
	wdcs_wd_t wd_reg;
	logic [31:0] wd_cnt_reg;
	logic [9:0] dly_cnt_reg;
	logic wd_fire;
	logic wd_reset;
	logic wr_go;
	logic [7:0] wr_off;
	logic [7:0] wr_byte;
	logic key_open;
	logic any_rst;
	logic [7:0] wdctl_next;

	function automatic logic [7:0] off_of(input logic [31:0] a);
		off_of = a[7:0];
	endfunction : off_of

	// Shared by the write response and the read response
	function automatic logic reg_mapped(input logic [7:0] off);
		case (off)
			`WDCS_OFF_WDCTL,
			`WDCS_OFF_IRQEN,
			`WDCS_OFF_IRQPRI,
			`WDCS_OFF_TAKEY,
			`WDCS_OFF_RSTCTL: reg_mapped = 1'b1;
			default: reg_mapped = 1'b0;
		endcase
	endfunction : reg_mapped

	// Write takes place once both address and data have been caught
	assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign wr_off = off_of(aw_addr_reg);
	// Only byte lane 0 carries register data
	assign wr_byte = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;
	assign key_open = (key_reg == WDCS_KEY_OPEN);
	// Compare with >= so no count value can step past expiry
	assign wd_fire = (wd_reg == WDCS_WD_RUN) && (wd_cnt_reg >= 32'(TIMEOUT_CLKS - 1));
	assign wd_reset = (wd_reg == WDCS_WD_DELAY) && (dly_cnt_reg == 10'(RST_DELAY - 1))
		&& wdctl_reg[`WDCS_BIT_RSTEN];
	assign any_rst = por_event || ext_reset || power_fail || watchdog_reset_out;

	// AXI write address and data channels, accepted in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 32'h0;
			s_axi_awready <= 1'b0;
		end else if (wr_go) begin
			aw_have_reg <= 1'b0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_reg && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_reg <= 1'b0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			s_axi_wready <= 1'b0;
		end else if (wr_go) begin
			w_have_reg <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_have_reg && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			// Unmapped offsets answer with an error and change no register, though any write still drops a half-entered key
			s_axi_bresp <= reg_mapped(wr_off) ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel: one cycle from address to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			s_axi_arready <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= reg_mapped(off_of(s_axi_araddr)) ? 2'h0 : 2'h2;
			case (off_of(s_axi_araddr))
				`WDCS_OFF_WDCTL: s_axi_rdata <= {24'h0, wdctl_reg};
				`WDCS_OFF_IRQEN: s_axi_rdata <= {24'h0, irq_enable_reg | `WDCS_IRQEN_RSVD};
				`WDCS_OFF_IRQPRI: s_axi_rdata <= {24'h0, irq_priority_reg};
				`WDCS_OFF_TAKEY: s_axi_rdata <= {31'h0, key_open};
				`WDCS_OFF_RSTCTL: s_axi_rdata <= 32'h0;
				default: s_axi_rdata <= 32'h0;
			endcase
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// Timed-access unlock; any other key write relocks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_reg <= WDCS_KEY_IDLE;
			key_cnt_reg <= 16'h0;
		end else if (wr_go && wr_off == `WDCS_OFF_TAKEY) begin
			key_cnt_reg <= 16'h0;
			if (wr_byte == `WDCS_KEY1) begin
				key_reg <= WDCS_KEY_HALF;
			end else if (wr_byte == `WDCS_KEY2 && key_reg == WDCS_KEY_HALF) begin
				key_reg <= WDCS_KEY_OPEN;
			end else begin
				key_reg <= WDCS_KEY_IDLE;
			end
		end else if (key_reg == WDCS_KEY_HALF && wr_go) begin
			key_reg <= WDCS_KEY_IDLE; // Key pair must be back to back
		end else if (key_reg == WDCS_KEY_OPEN) begin
			// Counted in core clocks, so a slow bus shortens the usable window
			if (key_cnt_reg == 16'(KEY_CLKS - 1)) begin
				key_reg <= WDCS_KEY_IDLE;
			end else begin
				key_cnt_reg <= key_cnt_reg + 16'h1;
			end
		end
	end

	// Watchdog timeout counter and post-interrupt reset delay
	// Every reset source restarts the count, so no stale expiry follows
	always_ff @(posedge aclk) begin
		if (!aresetn || any_rst || wdctl_reg[`WDCS_BIT_RESTART]) begin
			wd_reg <= WDCS_WD_RUN;
			wd_cnt_reg <= 32'h0;
			dly_cnt_reg <= 10'h0;
		end else begin
			case (wd_reg)
				WDCS_WD_RUN: begin
					if (wd_fire) begin
						wd_reg <= WDCS_WD_DELAY;
						dly_cnt_reg <= 10'h0;
					end else begin
						wd_cnt_reg <= wd_cnt_reg + 32'h1;
					end
				end
				WDCS_WD_DELAY: begin
					if (dly_cnt_reg == 10'(RST_DELAY - 1)) begin
						wd_reg <= WDCS_WD_RUN;
						wd_cnt_reg <= 32'h0;
					end else begin
						dly_cnt_reg <= dly_cnt_reg + 10'h1;
					end
				end
				default: wd_reg <= WDCS_WD_RUN;
			endcase
		end
	end

	// Reset pulse, one cycle, RST_DELAY + 1 clocks after the timeout cycle (registered from wd_reset)
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_reset_out <= 1'b0;
		end else begin
			watchdog_reset_out <= wd_reset;
		end
	end

	// Next control value; hardware sets land after software clears
	always_comb begin
		wdctl_next = wdctl_reg;
		if (por_event) begin
			wdctl_next = `WDCS_WDCTL_POR;
		end else if (ext_reset) begin
			// Reset cause and reset enable survive an external reset
			wdctl_next[`WDCS_BIT_BAUD2] = 1'b0;
			wdctl_next[5] = 1'b0;
			wdctl_next[`WDCS_BIT_IRQF] = 1'b0;
			wdctl_next[`WDCS_BIT_RESTART] = 1'b0;
		end else begin
			wdctl_next[`WDCS_BIT_RESTART] = 1'b0;
			if (power_fail) begin
				wdctl_next[`WDCS_BIT_RCAUSE] = 1'b0;
			end
			if (wr_go && wr_off == `WDCS_OFF_WDCTL && w_strb_reg[0]) begin
				wdctl_next[`WDCS_BIT_BAUD2] = wr_byte[`WDCS_BIT_BAUD2];
				wdctl_next[`WDCS_BIT_RCAUSE] = wr_byte[`WDCS_BIT_RCAUSE] && !power_fail;
				// Locked writes leave the protected bits as they were
				if (key_open) begin
					wdctl_next[`WDCS_BIT_POR] = wr_byte[`WDCS_BIT_POR];
					wdctl_next[`WDCS_BIT_RSTEN] = wr_byte[`WDCS_BIT_RSTEN];
					wdctl_next[`WDCS_BIT_IRQF] = wr_byte[`WDCS_BIT_IRQF];
					wdctl_next[`WDCS_BIT_RESTART] = wr_byte[`WDCS_BIT_RESTART];
				end
			end
			if (wd_fire) begin
				wdctl_next[`WDCS_BIT_IRQF] = 1'b1;
			end
			if (wd_reset) begin
				wdctl_next[`WDCS_BIT_RCAUSE] = 1'b1;
			end
		end
	end

	// Control register state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdctl_reg <= `WDCS_WDCTL_POR;
		end else begin
			wdctl_reg <= wdctl_next;
		end
	end

	// Reserved upper bits are not stored; the read path forces them high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_enable_reg <= 8'h00;
		end else if (wr_go && w_strb_reg[0] && wr_off == `WDCS_OFF_IRQEN) begin
			irq_enable_reg <= {3'h0, wr_byte[4:0]};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_priority_reg <= 8'h00;
		end else if (wr_go && w_strb_reg[0] && wr_off == `WDCS_OFF_IRQPRI) begin
			irq_priority_reg <= {3'h0, wr_byte[4:0]};
		end
	end

	// Enable bit 4 gates the request; the flag itself is never masked
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_irq_req <= 1'b0;
		end else begin
			watchdog_irq_req <= wdctl_reg[`WDCS_BIT_IRQF] && irq_enable_reg[`WDCS_BIT_IRQEN];
		end
	end

	// Priority only steers the controller; it never blocks the request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_irq_high <= 1'b0;
		end else begin
			watchdog_irq_high <= irq_priority_reg[`WDCS_BIT_IRQPRI];
		end
	end

	// Baud doubling is handed straight to the serial port
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port1_baud_double <= 1'b0;
		end else begin
			port1_baud_double <= wdctl_reg[`WDCS_BIT_BAUD2];
		end
	end
endmodule : wdcs_top
`default_nettype wire

// >>> verif/wdcs_top_chk.sv
// Port-level assertions for the watchdog control block
`timescale 1ns/1ns
`default_nettype none
module wdcs_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_event,
	input wire logic ext_reset,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic watchdog_reset_out,
	input wire logic watchdog_irq_req,
	input wire logic watchdog_irq_high,
	input wire logic port1_baud_double
);
	// Only same-edge address and data handshakes are judged
	wire aw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire ar = s_axi_arvalid && s_axi_arready;
	wire [7:0] wa = s_axi_awaddr[7:0];
	wire [7:0] ra = s_axi_araddr[7:0];
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_ctl_read: assert property (ar && ra == 8'hd8 |=> s_axi_rvalid && !s_axi_rresp)
		else $error("control read refused");
	a_eie_rsvd: assert property (ar && ra == 8'he8 |=> s_axi_rdata[7:5] == 3'h7)
		else $error("reserved enable bits low");
	a_pulse_one: assert property (watchdog_reset_out |=> !watchdog_reset_out)
		else $error("reset pulse too long");
	a_pri_write: assert property (aw && wa == 8'hf8 && s_axi_wdata[4] |-> ##[1:3] watchdog_irq_high)
		else $error("priority not applied");
	a_baud_write: assert property (aw && wa == 8'hd8 && s_axi_wdata[7] |-> ##[1:3] port1_baud_double)
		else $error("baud bit not applied");
	a_irq_enable: assert property (aw && wa == 8'he8 && !s_axi_wdata[4] |-> ##[1:3] !watchdog_irq_req)
		else $error("irq request not masked");
	a_por_load: assert property (por_event |-> ##[1:3] !port1_baud_double)
		else $error("power-on load missed");
	a_ext_load: assert property (ext_reset |-> ##[1:3] !port1_baud_double)
		else $error("external reset load missed");
endmodule : wdcs_chk
`default_nettype wire

// >>> verif/wdcs_top_tb.sv
// Self-checking bench for the watchdog control block
`timescale 1ns/1ns
`default_nettype none
module wdcs_top_tb;
	logic aclk, aresetn, por_event, ext_reset, power_fail;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic watchdog_reset_out, watchdog_irq_req, watchdog_irq_high, port1_baud_double;
	int num_errors = 0;
	int comparisons = 0;
	int n;
	// Short timeout keeps the run brief
	wdcs_top #(.TIMEOUT_CLKS(64)) dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.por_event(por_event),
		.ext_reset(ext_reset),
		.power_fail(power_fail),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.watchdog_reset_out(watchdog_reset_out),
		.watchdog_irq_req(watchdog_irq_req),
		.watchdog_irq_high(watchdog_irq_high),
		.port1_baud_double(port1_baud_double)
	);
	initial begin
		aclk = 0;
		forever #2 aclk = ~aclk;
	end
	task automatic test_done;
		$display("errors %0d, checks %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic chk(input string s, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic tout(input bit t);
		if (t) begin
			num_errors++;
			test_done();
		end
	endtask : tout
	task automatic wr(input logic [7:0] a, d, input logic [1:0] r);
		int i = 0;
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= {24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			i++;
		end while (!s_axi_bvalid && i < 60);
		s_axi_bready <= 1'b0;
		tout(i >= 60);
		chk("bresp", s_axi_bresp, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, e, input logic [1:0] r);
		int i = 0;
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			i++;
		end while (!s_axi_rvalid && i < 60);
		s_axi_rready <= 1'b0;
		tout(i >= 60);
		chk("rresp", s_axi_rresp, r);
		if (r == 2'h0) chk("rdata", s_axi_rdata, {24'h0, e});
	endtask : rd
	initial begin
		{aresetn, por_event, ext_reset, power_fail, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'h1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'hd8, 8'h40, 2'h0);
		rd(8'he8, 8'he0, 2'h0);
		rd(8'hf8, 8'h00, 2'h0);
		rd(8'h10, 8'h00, 2'h2);
		wr(8'hd8, 8'h82, 2'h0);
		rd(8'hd8, 8'hc0, 2'h0);
		repeat (80) @(posedge aclk);
		rd(8'hd8, 8'hc8, 2'h0);
		wr(8'he8, 8'h10, 2'h0);
		wr(8'hf8, 8'h10, 2'h0);
		@(posedge aclk);
		chk("irq_req", watchdog_irq_req, 1);
		chk("irq_high", watchdog_irq_high, 1);
		wr(8'hc7, 8'haa, 2'h0);
		wr(8'hc7, 8'h55, 2'h0);
		wr(8'hd8, 8'h03, 2'h0);
		rd(8'hd8, 8'h02, 2'h0);
		n = 0;
		while (!watchdog_irq_req && n < 200) begin
			@(posedge aclk);
			n++;
		end
		tout(n >= 200);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!watchdog_reset_out && n < 600);
		chk("rst_delay", n, 511);
		rd(8'hd8, 8'h0e, 2'h0);
		wr(8'he8, 8'h00, 2'h0);
		@(posedge aclk);
		chk("irq_req", watchdog_irq_req, 0);
		wr(8'he8, 8'h10, 2'h0);
		wr(8'hd8, 8'h84, 2'h0);
		rd(8'hd8, 8'h8e, 2'h0);
		ext_reset <= 1'b1;
		@(posedge aclk);
		ext_reset <= 1'b0;
		rd(8'hd8, 8'h06, 2'h0);
		power_fail <= 1'b1;
		@(posedge aclk);
		power_fail <= 1'b0;
		rd(8'hd8, 8'h02, 2'h0);
		wr(8'hd8, 8'h80, 2'h0);
		@(posedge aclk);
		chk("baud", port1_baud_double, 1);
		por_event <= 1'b1;
		@(posedge aclk);
		por_event <= 1'b0;
		rd(8'hd8, 8'h40, 2'h0);
		chk("baud", port1_baud_double, 0);
		wr(8'he8, 8'h00, 2'h0);
		test_done();
	end
endmodule : wdcs_top_tb
bind wdcs_top wdcs_chk chk_i (
	.aclk(aclk),
	.aresetn(aresetn),
	.por_event(por_event),
	.ext_reset(ext_reset),
	.s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.watchdog_reset_out(watchdog_reset_out),
	.watchdog_irq_req(watchdog_irq_req),
	.watchdog_irq_high(watchdog_irq_high),
	.port1_baud_double(port1_baud_double)
);
`default_nettype wire
